// ==== dv/pfc_pm_model.sv ====
// Purpose: program memory standing behind the core for the bench
// Assumes: the word at address a of bank b is {b, 1, a}, so every fetch is self-identifying
// Notes: core registers the address, so data follows it within the same pclk
module pfc_pm_model
(
   input wire logic [13:0] pm_addr, // word address
   input wire logic pm_bank, // bank select
   output logic [15:0] pm_data // read word
);
   timeunit 1ns;
   timeprecision 1ns;
   // content derived from the address, so no 16K array is held per bank
   always_comb begin
      pm_data = {pm_bank, 1'b1, pm_addr};
   end
endmodule : pfc_pm_model

// ==== dv/testbench.sv ====
// Purpose: self-checking bench for the program-flow core
// Assumes: bank 0 unless a test selects bank 1; decoder role played by the bench
// Notes: instruction-level checks sample 1 ns after the clock edge
module testbench
   import pfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk;
   logic presetn;
   logic [7:0] paddr;
   logic psel, penable, pwrite, pready, pslverr;
   logic [31:0] pwdata, prdata, rd;
   logic pm_bank, instr_valid, ext_int_pin, err;
   logic [13:0] pm_addr;
   logic [15:0] pm_data, instr_word;
   logic [1:0] instr_clock_phase;
   pfc_op_t op;
   pfc_evt_t evt;
   pfc_res_t res;
   int fails, samples_checked;

   pfc_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_bank(pm_bank),
      .pm_data(pm_data), .instr_word(instr_word), .instr_valid(instr_valid),
      .instr_clock_phase(instr_clock_phase), .op(op), .evt(evt),
      .ext_int_pin(ext_int_pin), .res(res));
   pfc_pm_model pmem (.pm_addr(pm_addr), .pm_bank(pm_bank), .pm_data(pm_data));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   function automatic logic [15:0] pmw(input logic [13:0] a);
      return {2'b01, a};
   endfunction : pmw

   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task done(input string name);
      $display("test %s finished", name);
   endtask : done

   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) fails++;
   endtask : apb

   // op shown during phase four of a valid slot, withdrawn at the edge that takes it
   task issue(input pfc_kind_t k, input logic [13:0] t, input logic s, output logic [13:0] at);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
      end while (!(instr_clock_phase === PH_T2 + 2'h1 && instr_valid === 1'b1) && ++n < 40);
      if (n >= 40) fails++;
      at = instr_word[13:0];
      @(posedge pclk);
      op.kind <= k;
      op.target <= t;
      op.skip <= s;
      @(posedge pclk);
      op.kind <= OP_SEQ;
      op.skip <= 1'b0;
      #1;
   endtask : issue

   // first valid word from the current cycle on, counting dummy cycles
   task nxt(output logic [15:0] w, output int d);
      d = 0;
      while (instr_valid !== 1'b1 && d < 8) begin
         d++;
         repeat (4) @(posedge pclk);
         #1;
      end
      w = instr_word;
   endtask : nxt

   task wait_word(input string name, input logic [13:0] a, input int lim, input logic e);
      logic hit;
      hit = 1'b0;
      repeat (lim) begin
         @(posedge pclk);
         #1;
         if (instr_valid === 1'b1 && instr_word === pmw(a)) hit = 1'b1;
      end
      chk(name, {15'h0, e}, {15'h0, hit});
   endtask : wait_word

   task t_seq;
      logic [15:0] w;
      int d;
      int n;
      n = 0;
      while (instr_valid !== 1'b1 && n < 20) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("reset vector word", pmw(RESET_VEC), instr_word);
      for (int i = 1; i < 4; i++) begin
         for (int j = 0; j < 4; j++) begin
            chk("phase", 16'(j), {14'h0, instr_clock_phase});
            @(posedge pclk);
            #1;
         end
         nxt(w, d);
         chk("sequential word", pmw(RESET_VEC + 14'(i)), w);
         chk("sequential dummies", 16'h0, 16'(d));
      end
      done("sequential");
   endtask : t_seq

   task t_alu;
      pfc_alu_t fl [11];
      logic [7:0] ex [11];
      logic [13:0] at;
      fl = '{F_ADD, F_AND, F_OR, F_XOR, F_SUB, F_ADC, F_INC, F_DEC, F_CPL, F_RR, F_RRC};
      ex = '{8'h10, 8'h20, 8'hf0, 8'hd0, 8'hd0, 8'h11, 8'hf1, 8'hef, 8'h0f, 8'h78, 8'hf8};
      for (int i = 0; i < 11; i++) begin
         @(posedge pclk);
         op.fn <= fl[i];
         op.a <= 8'hf0;
         op.b <= 8'h20;
         issue(OP_ALU, 14'h0, 1'b0, at);
         chk("alu strobe", 16'h1, {15'h0, res.alu_stb});
         chk("alu result", {8'h0, ex[i]}, {8'h0, res.alu_result});
         if (i == 0 || i == 10) chk("carry", {15'h0, i == 0}, {15'h0, res.status[ST_C]});
      end
      done("alu");
   endtask : t_alu

   task t_flow;
      logic [13:0] at, a2;
      logic [15:0] w;
      int d;
      issue(OP_SKIP, 14'h0, 1'b1, at);
      nxt(w, d);
      chk("skip taken word", pmw(at + 14'd2), w);
      chk("skip taken dummies", 16'h1, 16'(d));
      issue(OP_SKIP, 14'h0, 1'b0, at);
      nxt(w, d);
      chk("skip not taken", pmw(at + 14'd1), w);
      issue(OP_CALL, 14'h0200, 1'b0, at);
      nxt(w, d);
      chk("call target", pmw(14'h0200), w);
      chk("call dummies", 16'h1, 16'(d));
      issue(OP_RETURN, 14'h0, 1'b0, a2);
      nxt(w, d);
      chk("return word", pmw(at + 14'd1), w);
      issue(OP_JMP, 14'h0123, 1'b0, at);
      nxt(w, d);
      chk("jump target", pmw(14'h0123), w);
      chk("jump dummies", 16'h1, 16'(d));
      apb(1'b1, A_PC_LOW, 32'h77);
      chk("low byte write error", 16'h0, {15'h0, err});
      wait_word("page jump", 14'h0177, 24, 1'b1);
      apb(1'b0, A_PC_LOW, 32'h0);
      chk("low byte upper bits", 16'h0, rd[31:16]);
      done("flow");
   endtask : t_flow

   task trd(input string n, input pfc_kind_t k, input logic [7:0] p);
      logic [13:0] at, ta;
      logic [15:0] tw, e, w;
      int d;
      apb(1'b1, A_TBLP, {24'h0, p});
      issue(k, 14'h0, 1'b0, at);
      ta = {(k == OP_TRDL) ? LAST_PAGE : at[13:8], p};
      e = pmw(ta);
      tw = 'x;
      chk("table slot valid", 16'h0, {15'h0, instr_valid});
      repeat (4) begin
         if (res.tbl_stb === 1'b1) tw = {res.tbl_high, res.tbl_low};
         @(posedge pclk);
         #1;
      end
      chk(n, e, tw);
      nxt(w, d);
      chk("word after table", pmw(at + 14'd1), w);
      apb(1'b1, A_TBL_HIGH, 32'h0);
      apb(1'b0, A_TBL_HIGH, 32'h0);
      chk("table high latch", {8'h0, e[15:8]}, rd[15:0]);
      done(n);
   endtask : trd

   task t_bank;
      apb(1'b1, A_BANK_SEL, 32'h20);
      repeat (2) @(posedge pclk);
      chk("bank select", 16'h1, {15'h0, pm_bank});
      apb(1'b1, A_BANK_SEL, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 16'h1, {15'h0, err});
      done("bank");
   endtask : t_bank

   task t_ext;
      logic [13:0] at;
      apb(1'b1, A_INTC, 32'h203);
      @(posedge pclk);
      ext_int_pin <= 1'b1;
      wait_word("rising edge ignored", INT_VEC[0], 24, 1'b0);
      @(posedge pclk);
      ext_int_pin <= 1'b0;
      wait_word("falling edge vector", INT_VEC[0], 40, 1'b1);
      issue(OP_IRQ_RETURN, 14'h0, 1'b0, at);
      done("external");
   endtask : t_ext

   // eight nested calls fill the stack; a pending request waits for a return
   task t_full;
      logic [13:0] at;
      logic [15:0] w;
      int d;
      for (int i = 0; i < 8; i++) begin
         issue(OP_CALL, 14'h0300 + 14'(16 * i), 1'b0, at);
         nxt(w, d);
      end
      apb(1'b1, A_INTC, 32'h21);
      @(posedge pclk);
      evt.adc_done <= 1'b1;
      @(posedge pclk);
      evt.adc_done <= 1'b0;
      wait_word("held while full", INT_VEC[4], 24, 1'b0);
      issue(OP_CALL, 14'h0400, 1'b0, at);
      nxt(w, d);
      chk("call on full stack", pmw(14'h0400), w);
      for (int i = 0; i < 2; i++) begin
         issue(OP_RETURN, 14'h0, 1'b0, at);
         nxt(w, d);
      end
      wait_word("served after return", INT_VEC[4], 40, 1'b1);
      done("stack full");
   endtask : t_full

   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      op = '0;
      evt = '0;
      ext_int_pin = 1'b0;
      fails = 0;
      samples_checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_seq();
      t_alu();
      t_flow();
      trd("current page table", OP_TRDC, 8'h40);
      trd("last page table", OP_TRDL, 8'h06);
      t_bank();
      t_ext();
      t_full();
      finish_test();
   end

   // the whole sequence needs several hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      finish_test();
   end
endmodule : testbench

// ==== rtl/pfc_core.sv ====
// Purpose: program-flow core: phases, program counter, return stack, vectors, alu, tables
// Assumes: decoder on pclk drives op for the word on instr_word before the T4 edge
// Notes: program memory returns pm_data within the same pclk in which pm_addr changes
// What this block does
// - four pclk phases make one instruction cycle
// - pc advances and fetch starts in phase one; fetched word is captured in phase two; execute takes effect at the phase four edge
// - jumps and calls take two instruction cycles
// - pc is 14 bits, six high bits plus a software-visible low byte
// - taken skip discards the prefetched word and runs a dummy cycle
// - low byte write jumps within the 256-word page, with a dummy cycle
// - stack holds pc values only; stack and pointer invisible to software
// - call and interrupt push pc; returns pop it
// - reset points the stack pointer at the top of stack
// - full stack keeps interrupt flag but withholds acknowledge until a return
// - call on full stack still proceeds and overflows
// - alu does arithmetic, logic, rotates, inc/dec and updates status flags
// - 16K by 16 program memory addressed by the pc
// - bit five of bank pointer picks the program bank
// - reset loads the reset vector into the pc
// - selected edge on external pin vectors when enabled and stack not full
// - timer 0 or 1 overflow vectors to its own location
// - timer 2 or touch counter overflow vectors to multi-function location
// - conversion done vectors to the converter location
// - touch-key overflow vectors to the touch-key location
// - table read uses table pointer as low address; fills low and high latch
// - unbacked high table bits read as zero
// - current-page read takes pc high bits; last-page read forces ones
// - every table read takes two instruction cycles
module pfc_core
   import pfc_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, low active
   input wire logic [7:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   output logic [13:0] pm_addr, // program memory address
   output logic pm_bank, // program memory bank
   input wire logic [15:0] pm_data, // program memory word
   output logic [15:0] instr_word, // word in execute slot
   output logic instr_valid, // execute slot holds a real word
   output logic [1:0] instr_clock_phase, // current phase, 0 is phase one
   input wire pfc_op_t op, // decoded operation for instr_word
   input wire pfc_evt_t evt, // peripheral event pulses
   input wire logic ext_int_pin, // external interrupt pin
   output pfc_res_t res // alu and table results
);
   pfc_state_t s;
   pfc_state_t n;
   logic exe;
   logic fchg;
   logic ack_go;
   logic acc;
   logic err;
   logic wr_done;
   logic ext_edge;
   logic [5:0] src;
   logic [5:0] pend;
   logic [5:0] ack_vec;
   logic [5:0] nflag;
   logic [5:0] w1c;
   logic [6:0][13:0] vacc;
   logic [7:0] rd;

   assign ext_edge = (s.esel[0] & s.xsync[1] & ~s.xprev)
                   | (s.esel[1] & ~s.xsync[1] & s.xprev);
   assign src = {evt.tk_ovf, evt.adc_done,
                 evt.tmr2_ovf | evt.tk16_ovf | evt.tk10_ovf,
                 evt.tmr1_ovf, evt.tmr0_ovf, ext_edge};
   assign pend = s.iflag & s.ien;
   assign exe = s.ph == PH_T4 && !s.tslot && !s.pc_low_pend && s.evalid;
   assign fchg = exe && (op.kind inside {OP_JMP, OP_CALL, OP_RETURN, OP_IRQ_RETURN, OP_TRDC,
                 OP_TRDL}
                 || (op.kind == OP_SKIP && op.skip));
   // only at a sequential boundary, so one push at most per cycle
   assign ack_go = s.ph == PH_T4 && !s.tslot && !s.pc_low_pend && !fchg
                 && s.emi && (|pend) && !s.sp[3];
   assign ack_vec = ack_go ? (pend & (~pend + 6'h01)) : 6'h00;
   assign acc = psel && penable;
   assign err = !(paddr inside {A_PC_LOW, A_BANK_SEL, A_TBLP, A_TBL_HIGH, A_TBLL, A_INTC, A_IFLG,
                                A_STAT});
   assign wr_done = acc && s.pready && pwrite && !err;
   assign w1c = (wr_done && paddr == A_IFLG) ? pwdata[5:0] : 6'h00;
   assign vacc[0] = 14'h0000;

   // new event wins over a clear in the same cycle
   for (genvar gi = 0; gi < N_IRQ; gi++) begin : g_irq
      assign nflag[gi] = src[gi] | (s.iflag[gi] & ~w1c[gi] & ~ack_vec[gi]);
      assign vacc[gi + 1] = vacc[gi] | (ack_vec[gi] ? INT_VEC[gi] : 14'h0000);
   end

   // stack is deliberately absent from the map
   always_comb begin
      rd = 8'h00;
      case (paddr)
         A_PC_LOW: rd = s.pc[7:0];
         A_BANK_SEL: rd = s.bank_ptr;
         A_TBLP: rd = s.tblp;
         A_TBL_HIGH: rd = s.tbl_hi;
         A_TBLL: rd = s.tbll;
         A_INTC: rd = {s.esel[0], s.ien, s.emi};
         A_IFLG: rd = {2'h0, s.iflag};
         A_STAT: rd = {4'h0, s.stat};
         default: rd = 8'h00;
      endcase
   end

   always_comb begin
      logic [8:0] sum;
      logic [4:0] hsum;
      logic [7:0] bb;
      logic [7:0] r;
      logic ci;
      logic [3:0] pidx;
      sum = 9'h000;
      hsum = 5'h00;
      bb = op.b;
      r = 8'h00;
      ci = 1'b0;
      pidx = s.sp - 4'h1;
      n = s;
      n.ph = s.ph + 2'h1;
      n.res_stb = 1'b0;
      n.tbl_stb = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.xsync = {s.xsync[0], ext_int_pin};
      n.xprev = s.xsync[1];
      n.iflag = nflag;
      case (op.fn)
         F_ADC: ci = s.stat[ST_C];
         F_SUB: begin
            bb = ~op.b;
            ci = 1'b1;
         end
         F_SBC: begin
            bb = ~op.b;
            ci = s.stat[ST_C];
         end
         F_INC: bb = 8'h01;
         F_DEC: bb = 8'hff;
         default: ;
      endcase
      sum = {1'b0, op.a} + {1'b0, bb} + {8'h00, ci};
      hsum = {1'b0, op.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      case (s.ph)
         PH_T1: begin
            n.pm_addr = s.tslot ? s.taddr : s.pc;
            if (!s.tslot) begin
               n.pc = s.pc + 14'h0001;
               n.fa = s.pc;
            end
         end
         PH_T2: begin
            if (s.tslot) begin
               n.tbl_hi = pm_data[15:8] & TBL_HIGH_MASK;
               n.tbll = pm_data[7:0];
               n.tbl_stb = 1'b1;
            end else begin
               n.fetched = pm_data;
               n.fvalid = 1'b1;
            end
         end
         PH_T4: begin
            n.exec = s.fetched;
            n.evalid = s.fvalid;
            if (s.tslot) begin
               n.tslot = 1'b0;
            end else if (s.pc_low_pend) begin
               // word in the execute slot is dropped along with the prefetch
               n.pc = {s.pc[13:8], s.pc_low_val};
               n.evalid = 1'b0;
               n.pc_low_pend = 1'b0;
            end else if (s.evalid) begin
               case (op.kind)
                  OP_JMP: begin
                     n.pc = op.target;
                     n.evalid = 1'b0;
                  end
                  OP_CALL: begin
                     // no full check: a ninth call overwrites level zero
                     n.stk[s.sp[2:0]] = s.fa;
                     n.sp = s.sp + 4'h1;
                     n.pc = op.target;
                     n.evalid = 1'b0;
                  end
                  OP_RETURN, OP_IRQ_RETURN: begin
                     n.pc = s.stk[pidx[2:0]];
                     if (s.sp != 4'h0) begin
                        n.sp = pidx;
                     end
                     if (op.kind == OP_IRQ_RETURN) begin
                        n.emi = 1'b1;
                     end
                     n.evalid = 1'b0;
                  end
                  OP_SKIP: begin
                     if (op.skip) begin
                        n.evalid = 1'b0;
                     end
                  end
                  OP_TRDC, OP_TRDL: begin
                     n.taddr = {(op.kind == OP_TRDL) ? LAST_PAGE : s.pc[13:8], s.tblp};
                     n.tslot = 1'b1;
                     n.evalid = 1'b0;
                  end
                  OP_ALU: begin
                     case (op.fn)
                        F_ADD, F_ADC, F_SUB, F_SBC: begin
                           r = sum[7:0];
                           n.stat[ST_C] = sum[8];
                           n.stat[ST_AC] = hsum[4];
                           n.stat[ST_OV] = (op.a[7] == bb[7]) && (sum[7] != op.a[7]);
                        end
                        F_INC, F_DEC: r = sum[7:0];
                        F_DAA: begin
                           sum = {1'b0, op.a};
                           if (op.a[3:0] > 4'h9 || s.stat[ST_AC]) begin
                              sum = sum + 9'h006;
                           end
                           if (sum[7:4] > 4'h9 || sum[8] || s.stat[ST_C]) begin
                              sum = sum + 9'h060;
                           end
                           r = sum[7:0];
                           n.stat[ST_C] = sum[8] | s.stat[ST_C];
                        end
                        F_AND: r = op.a & op.b;
                        F_OR: r = op.a | op.b;
                        F_XOR: r = op.a ^ op.b;
                        F_CPL: r = ~op.a;
                        F_RR: r = {op.a[0], op.a[7:1]};
                        F_RL: r = {op.a[6:0], op.a[7]};
                        F_RRC: begin
                           r = {s.stat[ST_C], op.a[7:1]};
                           n.stat[ST_C] = op.a[0];
                        end
                        F_RLC: begin
                           r = {op.a[6:0], s.stat[ST_C]};
                           n.stat[ST_C] = op.a[7];
                        end
                        default: r = op.a;
                     endcase
                     if (!(op.fn inside {F_RR, F_RL, F_RRC, F_RLC})) begin
                        n.stat[ST_Z] = (r == 8'h00);
                     end
                     n.alu_res = r;
                     n.res_stb = 1'b1;
                  end
                  default: ;
               endcase
            end
            if (ack_go) begin
               n.stk[s.sp[2:0]] = s.fa;
               n.sp = s.sp + 4'h1;
               n.pc = vacc[N_IRQ];
               n.emi = 1'b0;
               n.evalid = 1'b0;
            end
         end
         default: ;
      endcase
      // software writes land after the pipeline so a fresh low byte write is kept
      if (acc && !s.pready) begin
         n.pready = 1'b1;
         n.prdata = {24'h000000, rd};
         n.pslverr = err;
      end
      if (wr_done) begin
         case (paddr)
            A_PC_LOW: begin
               n.pc_low_pend = 1'b1;
               n.pc_low_val = pwdata[7:0];
            end
            A_BANK_SEL: n.bank_ptr = pwdata[7:0];
            A_TBLP: n.tblp = pwdata[7:0];
            A_INTC: begin
               n.emi = pwdata[IC_EMI];
               n.ien = pwdata[IC_IEN +: N_IRQ];
               n.esel = pwdata[IC_ESEL +: 2];
            end
            A_STAT: n.stat = pwdata[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.pc <= RESET_VEC;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign pm_addr = s.pm_addr;
   assign pm_bank = s.bank_ptr[BANK_PM_BIT];
   assign instr_word = s.exec;
   assign instr_valid = s.evalid;
   assign instr_clock_phase = s.ph;
   assign res = '{alu_stb: s.res_stb, alu_result: s.alu_res, status: s.stat,
                  tbl_stb: s.tbl_stb, tbl_low: s.tbll, tbl_high: s.tbl_hi};

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_dummy;
      !s.evalid ##4 s.evalid;
   endsequence

   a_phase_wrap: assert property (s.ph == PH_T4 |=> s.ph == PH_T1 ##3 s.ph == PH_T4)
      else $error("phase sequence broken");
   a_fetch_t1: assert property (s.ph == PH_T1 && !s.tslot
      |=> s.pm_addr == $past(s.pc) && s.pc == $past(s.pc) + 14'h0001)
      else $error("fetch not at phase one");
   a_jump_two: assert property (exe && op.kind == OP_JMP
      |=> s.pc == $past(op.target) ##0 seq_dummy)
      else $error("jump not two cycles");
   a_skip_drop: assert property (exe && op.kind == OP_SKIP && op.skip |=> seq_dummy)
      else $error("skip did not insert dummy");
   a_low_page: assert property (s.ph == PH_T4 && !s.tslot && s.pc_low_pend
      |=> s.pc == {$past(s.pc[13:8]), $past(s.pc_low_val)} && !s.evalid)
      else $error("pcl jump left page");
   a_call_push: assert property (exe && op.kind == OP_CALL
      |=> s.sp == $past(s.sp) + 4'h1 && s.stk[$past(s.sp[2:0])] == $past(s.fa))
      else $error("call did not push");
   a_full_hold: assert property (s.sp[3] && s.ph == PH_T4 && !fchg
      |=> s.sp == $past(s.sp))
      else $error("ack while stack full");
   a_ack_vector: assert property (ack_go
      |=> s.pc == $past(vacc[N_IRQ]) && s.sp == $past(s.sp) + 4'h1)
      else $error("interrupt not vectored");
   a_tbl_last: assert property (exe && op.kind == OP_TRDL
      |=> s.taddr[13:8] == LAST_PAGE ##1 s.pm_addr == s.taddr ##2 !s.evalid ##1 s.evalid)
      else $error("last page table read wrong");
   a_alu_add: assert property (exe && op.kind == OP_ALU && op.fn == F_ADD
      |=> s.alu_res == 8'($past(op.a) + $past(op.b)) && s.res_stb)
      else $error("add result wrong");
endmodule : pfc_core

// ==== rtl/pfc_pkg.sv ====
// Purpose: shared types and constants of the program-flow core
// Assumes: one system clock, 16-bit program words, 14-bit program addresses
// Notes: vector addresses and register offsets are fixed here only
package pfc_pkg;
   localparam logic [13:0] RESET_VEC = 14'h0000;
   localparam int N_IRQ = 6;
   // index 0 ext, 1 timer0, 2 timer1, 3 multi-function, 4 adc, 5 touch key
   localparam logic [5:0][13:0] INT_VEC = {14'h0018, 14'h0014, 14'h0010,
                                           14'h000c, 14'h0008, 14'h0004};
   localparam logic [5:0] LAST_PAGE = 6'h3f;
   // every high table bit is backed by a program bit; mask keeps the zero fill explicit
   localparam logic [7:0] TBL_HIGH_MASK = 8'hff;
   localparam logic [1:0] PH_T1 = 2'h0;
   localparam logic [1:0] PH_T2 = 2'h1;
   localparam logic [1:0] PH_T4 = 2'h3;
   localparam logic [7:0] A_PC_LOW = 8'h00;
   localparam logic [7:0] A_BANK_SEL = 8'h04;
   localparam logic [7:0] A_TBLP = 8'h08;
   localparam logic [7:0] A_TBL_HIGH = 8'h0c;
   localparam logic [7:0] A_TBLL = 8'h10;
   localparam logic [7:0] A_INTC = 8'h14;
   localparam logic [7:0] A_IFLG = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1c;
   localparam int IC_EMI = 0;
   localparam int IC_IEN = 1;
   localparam int IC_ESEL = 8;
   localparam int BANK_PM_BIT = 5;
   localparam int ST_C = 0;
   localparam int ST_AC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;

   typedef enum logic [3:0] {OP_SEQ, OP_JMP, OP_CALL, OP_RETURN, OP_IRQ_RETURN,
                             OP_SKIP, OP_TRDC, OP_TRDL, OP_ALU} pfc_kind_t;
   typedef enum logic [3:0] {F_ADD, F_ADC, F_SUB, F_SBC, F_DAA, F_AND, F_OR, F_XOR,
                             F_CPL, F_RR, F_RRC, F_RL, F_RLC, F_INC, F_DEC} pfc_alu_t;

   typedef struct packed {
      pfc_kind_t kind;
      logic [13:0] target;
      logic skip;
      pfc_alu_t fn;
      logic [7:0] a;
      logic [7:0] b;
   } pfc_op_t;

   typedef struct packed {
      logic tk_ovf;
      logic adc_done;
      logic tk10_ovf;
      logic tk16_ovf;
      logic tmr2_ovf;
      logic tmr1_ovf;
      logic tmr0_ovf;
   } pfc_evt_t;

   typedef struct packed {
      logic alu_stb;
      logic [7:0] alu_result;
      logic [3:0] status;
      logic tbl_stb;
      logic [7:0] tbl_low;
      logic [7:0] tbl_high;
   } pfc_res_t;

   typedef struct packed {
      logic [1:0] ph;
      logic [13:0] pc;
      logic [13:0] fa;
      logic [13:0] pm_addr;
      logic [15:0] fetched;
      logic [15:0] exec;
      logic fvalid;
      logic evalid;
      logic tslot;
      logic [13:0] taddr;
      logic [7:0][13:0] stk;
      logic [3:0] sp;
      logic [7:0] bank_ptr;
      logic [7:0] tblp;
      logic [7:0] tbl_hi;
      logic [7:0] tbll;
      logic [7:0] alu_res;
      logic [3:0] stat;
      logic res_stb;
      logic tbl_stb;
      logic pc_low_pend;
      logic [7:0] pc_low_val;
      logic emi;
      logic [5:0] ien;
      logic [5:0] iflag;
      logic [1:0] esel;
      logic [1:0] xsync;
      logic xprev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pfc_state_t;
endpackage : pfc_pkg
